// *** ulsep_pkg.sv ***
// Shared constants and types of the low-speed USB endpoint control block.
// Assumes one clock domain and an 8-bit register port between the two ends.
package ulsep_pkg;

    // Register indices on the device register port.
    localparam logic [1:0] IDX_ADDR = 2'h0;
    localparam logic [1:0] IDX_IRQ0 = 2'h1;
    localparam logic [1:0] IDX_IRQ1 = 2'h2;
    localparam logic [1:0] IDX_CTL0 = 2'h3;

    // Field positions shared by several registers.
    localparam int BIT_7 = 7;
    localparam int BIT_6 = 6;
    localparam int BIT_5 = 5;
    localparam int BIT_4 = 4;
    localparam int BIT_3 = 3;
    localparam int BIT_2 = 2;
    localparam int BIT_1 = 1;
    localparam int BIT_0 = 0;

    // Controller APB register byte addresses.
    localparam logic [7:0] APB_INDEX = 8'h00;
    localparam logic [7:0] APB_WDATA = 8'h04;
    localparam logic [7:0] APB_CMD = 8'h08;
    localparam logic [7:0] APB_STATUS = 8'h0C;
    localparam int CMD_WRITE_BIT = 0;
    localparam int CMD_READ_BIT = 1;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_IRQ_BIT = 1;
    localparam int ST_IDLE_BIT = 2;
    localparam int ST_SUSP_BIT = 3;
    localparam int ST_RDATA_LSB = 8;

    // Bus idle time before firmware may suspend, and the clock rate.
    localparam int IDLE_TIME_US = 3000;
    localparam int CLK_MHZ = 100;
    localparam int IDLE_CYCLES = IDLE_TIME_US * CLK_MHZ;

    // Token kinds reported by the serial engine.
    typedef enum logic [1:0] {
        TOK_OUT,
        TOK_IN,
        TOK_SETUP,
        TOK_OTHER
    } ulsep_token_type;

    // Answer chosen for a token.
    typedef enum logic [2:0] {
        RESP_NONE,
        RESP_ACK,
        RESP_NAK,
        RESP_STALL,
        RESP_DATA
    } ulsep_resp_type;

endpackage : ulsep_pkg

// *** ulsep_if.sv ***
// Register port joining the endpoint control logic and its controller.
// Assumes both ends run on the same clock.
interface ulsep_if;
    logic sel;
    logic wr;
    logic [1:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic irq;

    modport device (
        input sel,
        input wr,
        input idx,
        input wdata,
        output rdata,
        output irq
    );

    modport ctrl (
        output sel,
        output wr,
        output idx,
        output wdata,
        input rdata,
        input irq
    );
endinterface : ulsep_if

// *** ulsep_ctrl.sv ***
// Controller end: an APB slave that turns software commands into accesses
// on the device register port and shows the answers and bus idle status.
// Assumes bus_activity comes from logic on pclk.
module ulsep_ctrl #(
    parameter int IDLE_COUNT = ulsep_pkg::IDLE_CYCLES
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Bus activity seen on the link.
    input wire logic bus_activity,
    // Device register port.
    ulsep_if.ctrl dev
);

    typedef struct packed {
        logic [1:0] idx;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic sel;
        logic wr;
        logic wait_rd;
        logic [31:0] prdata;
        logic [31:0] idle_cnt;
        logic idle;
    } ulsep_ctrl_state_type;

    ulsep_ctrl_state_type s_q;
    ulsep_ctrl_state_type s_d;
    logic acc;

    assign acc = psel && penable;

    always_comb begin
        s_d = s_q;
        s_d.sel = 1'b0;
        if (s_q.wait_rd && !s_q.sel) begin
            s_d.rdata = dev.rdata;
            s_d.wait_rd = 1'b0;
        end
        if (acc && pwrite) begin
            case (paddr)
                ulsep_pkg::APB_INDEX: s_d.idx = pwdata[1:0];
                ulsep_pkg::APB_WDATA: s_d.wdata = pwdata[7:0];
                ulsep_pkg::APB_CMD: begin
                    if (!s_q.sel && !s_q.wait_rd) begin
                        if (pwdata[ulsep_pkg::CMD_WRITE_BIT]) begin
                            s_d.sel = 1'b1;
                            s_d.wr = 1'b1;
                        end else if (pwdata[ulsep_pkg::CMD_READ_BIT]) begin
                            s_d.sel = 1'b1;
                            s_d.wr = 1'b0;
                            s_d.wait_rd = 1'b1;
                        end
                    end
                end
                default: ;
            endcase
        end
        s_d.prdata = 32'h0;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                ulsep_pkg::APB_INDEX: s_d.prdata = {30'h0, s_q.idx};
                ulsep_pkg::APB_WDATA: s_d.prdata = {24'h0, s_q.wdata};
                ulsep_pkg::APB_STATUS: begin
                    s_d.prdata[ulsep_pkg::ST_BUSY_BIT] = s_q.sel | s_q.wait_rd;
                    s_d.prdata[ulsep_pkg::ST_IRQ_BIT] = dev.irq;
                    s_d.prdata[ulsep_pkg::ST_IDLE_BIT] = s_q.idle;
                    s_d.prdata[ulsep_pkg::ST_SUSP_BIT] =
                        s_q.rdata[ulsep_pkg::BIT_4];
                    s_d.prdata[ulsep_pkg::ST_RDATA_LSB +: 8] = s_q.rdata;
                end
                default: s_d.prdata = 32'h0;
            endcase
        end
        // Idle time after which software may set the suspend bit.
        if (bus_activity) begin
            s_d.idle_cnt = 32'h0;
            s_d.idle = 1'b0;
        end else if (s_q.idle_cnt >= 32'(IDLE_COUNT - 1)) begin
            s_d.idle = 1'b1;
        end else begin
            s_d.idle_cnt = s_q.idle_cnt + 32'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign dev.sel = s_q.sel;
    assign dev.wr = s_q.wr;
    assign dev.idx = s_q.idx;
    assign dev.wdata = s_q.wdata;

endmodule : ulsep_ctrl

// *** ulsep_dev.sv ***
// Device end: registers, flags and token answers of the low-speed USB
// function's control logic. Assumes the serial engine on pclk reports
// tokens and completed handshakes as one-cycle pulses.

// Behaviour
// - Disabled module ignores tokens, pins off.
// - Seven-bit address, reset zero, matched.
// - Set tx-done after ACKed control transmit.
// - NAK control IN if disabled or done.
// - Writing one clears tx-done flag.
// - Set rx-done after ACKed control receive.
// - NAK control OUT if disabled or done.
// - Writing one clears rx-done flag.
// - Bus reset sets flag, resets system.
// - Suspend gates clock, powers analog down.
// - Firmware suspends after idle, clears later.
// - Control flags interrupt when enabled.
// - Shared tx-done set, NAKs further INs.
// - Writing one clears shared tx-done.
// - End-of-packet flag set, write-one clear.
// - Bus activity in suspend sets wakeup.
// - Shared and EOP flags interrupt enabled.
// - Toggle bit picks DATA1 or DATA0.
// - Stall answers STALL, SETUP clears it.
// - Four-bit count sizes control IN.
// - Firmware re-enables receive and transmit.
// - Firmware reads buffer before clearing.
// - All sources share one interrupt line.
module ulsep_dev #(
    parameter int ADDR_W = 7,
    parameter int CNT_W = 4
) (
    // Clock and power-on reset.
    input wire logic pclk,
    input wire logic presetn,
    // Register port.
    ulsep_if.device regs,
    // Tokens from the serial engine.
    input wire logic token_valid,
    input wire ulsep_pkg::ulsep_token_type token_kind,
    input wire logic [ADDR_W-1:0] token_addr,
    input wire logic [1:0] token_ep,
    input wire logic shared_tx_ready,
    // Completion events from the serial engine.
    input wire logic ctl_tx_acked,
    input wire logic ctl_rx_acked,
    input wire logic shared_tx_acked,
    input wire logic eop_detect,
    input wire logic bus_reset_detect,
    input wire logic bus_activity,
    // Answers to the serial engine.
    output ulsep_pkg::ulsep_resp_type resp,
    output logic resp_valid,
    output logic resp_data1,
    output logic [CNT_W-1:0] resp_count,
    // Module control.
    output logic usb_pins_enable,
    output logic usb_clock_stop,
    output logic analog_power_down,
    output logic system_reset
);

    typedef struct packed {
        logic enable;
        logic [ADDR_W-1:0] faddr;
        logic tx_done;
        logic rx_done;
        logic bus_reset;
        logic suspend;
        logic tx_ie;
        logic rx_ie;
        logic sh_done;
        logic eop;
        logic wakeup;
        logic sh_ie;
        logic eop_ie;
        logic toggle;
        logic stall;
        logic tx_en;
        logic rx_en;
        logic [CNT_W-1:0] count;
        logic [7:0] rdata;
        logic irq;
        ulsep_pkg::ulsep_resp_type resp;
        logic resp_valid;
        logic data1;
        logic [CNT_W-1:0] resp_count;
        logic sysrst;
    } ulsep_dev_state_type;

    ulsep_dev_state_type s_q;
    ulsep_dev_state_type s_d;
    logic wr_hit;
    logic hit;

    function automatic logic [7:0] read_reg(input ulsep_dev_state_type s,
                                            input logic [1:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            ulsep_pkg::IDX_ADDR: v = {s.enable, s.faddr};
            ulsep_pkg::IDX_IRQ0: v = {s.tx_done, s.rx_done, s.bus_reset,
                                      s.suspend, s.tx_ie, s.rx_ie, 2'h0};
            ulsep_pkg::IDX_IRQ1: v = {s.sh_done, s.eop, s.wakeup, 1'h0,
                                      s.sh_ie, s.eop_ie, 2'h0};
            ulsep_pkg::IDX_CTL0: v = {s.toggle, s.stall, s.tx_en, s.rx_en,
                                      s.count};
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_reg

    assign wr_hit = regs.sel && regs.wr;
    // Tokens count only when enabled and addressed to this function.
    assign hit = token_valid && s_q.enable && token_addr == s_q.faddr;

    always_comb begin
        s_d = s_q;
        s_d.resp = ulsep_pkg::RESP_NONE;
        s_d.resp_valid = 1'b0;
        s_d.sysrst = 1'b0;
        // Software writes; clear strobes act only when their bit is one.
        if (wr_hit) begin
            case (regs.idx)
                ulsep_pkg::IDX_ADDR: begin
                    s_d.enable = regs.wdata[ulsep_pkg::BIT_7];
                    s_d.faddr = regs.wdata[ADDR_W-1:0];
                end
                ulsep_pkg::IDX_IRQ0: begin
                    s_d.suspend = regs.wdata[ulsep_pkg::BIT_4];
                    s_d.tx_ie = regs.wdata[ulsep_pkg::BIT_3];
                    s_d.rx_ie = regs.wdata[ulsep_pkg::BIT_2];
                    if (regs.wdata[ulsep_pkg::BIT_1]) begin
                        s_d.tx_done = 1'b0;
                    end
                    if (regs.wdata[ulsep_pkg::BIT_0]) begin
                        s_d.rx_done = 1'b0;
                    end
                end
                ulsep_pkg::IDX_IRQ1: begin
                    if (regs.wdata[ulsep_pkg::BIT_4]) begin
                        s_d.wakeup = 1'b0;
                    end
                    s_d.sh_ie = regs.wdata[ulsep_pkg::BIT_3];
                    s_d.eop_ie = regs.wdata[ulsep_pkg::BIT_2];
                    if (regs.wdata[ulsep_pkg::BIT_1]) begin
                        s_d.sh_done = 1'b0;
                    end
                    if (regs.wdata[ulsep_pkg::BIT_0]) begin
                        s_d.eop = 1'b0;
                    end
                end
                ulsep_pkg::IDX_CTL0: begin
                    s_d.toggle = regs.wdata[ulsep_pkg::BIT_7];
                    s_d.stall = regs.wdata[ulsep_pkg::BIT_6];
                    s_d.tx_en = regs.wdata[ulsep_pkg::BIT_5];
                    s_d.rx_en = regs.wdata[ulsep_pkg::BIT_4];
                    s_d.count = regs.wdata[CNT_W-1:0];
                end
                default: ;
            endcase
        end
        if (regs.sel && !regs.wr) begin
            s_d.rdata = read_reg(s_q, regs.idx);
        end
        // Token answers.
        if (hit) begin
            s_d.resp_valid = 1'b1;
            if (token_ep == 2'h0) begin
                case (token_kind)
                    ulsep_pkg::TOK_IN: begin
                        if (s_q.stall) begin
                            s_d.resp = ulsep_pkg::RESP_STALL;
                        end else if (!s_q.tx_en || s_q.tx_done) begin
                            s_d.resp = ulsep_pkg::RESP_NAK;
                        end else begin
                            s_d.resp = ulsep_pkg::RESP_DATA;
                            s_d.data1 = s_q.toggle;
                            s_d.resp_count = s_q.count;
                        end
                    end
                    ulsep_pkg::TOK_OUT: begin
                        if (s_q.stall) begin
                            s_d.resp = ulsep_pkg::RESP_STALL;
                        end else if (!s_q.rx_en || s_q.rx_done) begin
                            s_d.resp = ulsep_pkg::RESP_NAK;
                        end else begin
                            s_d.resp = ulsep_pkg::RESP_ACK;
                        end
                    end
                    ulsep_pkg::TOK_SETUP: begin
                        s_d.stall = 1'b0;
                        s_d.resp = ulsep_pkg::RESP_ACK;
                    end
                    default: s_d.resp_valid = 1'b0;
                endcase
            end else if (token_kind == ulsep_pkg::TOK_IN) begin
                if (s_q.sh_done || !shared_tx_ready) begin
                    s_d.resp = ulsep_pkg::RESP_NAK;
                end else begin
                    s_d.resp = ulsep_pkg::RESP_DATA;
                end
            end else begin
                s_d.resp_valid = 1'b0;
            end
        end
        // Hardware events; a set wins over a clear in the same cycle.
        if (ctl_tx_acked) begin
            s_d.tx_done = 1'b1;
        end
        if (ctl_rx_acked) begin
            s_d.rx_done = 1'b1;
        end
        if (shared_tx_acked) begin
            s_d.sh_done = 1'b1;
        end
        if (eop_detect) begin
            s_d.eop = 1'b1;
        end
        if (bus_activity && s_q.suspend) begin
            s_d.wakeup = 1'b1;
        end
        if (bus_reset_detect) begin
            s_d.bus_reset = 1'b1;
            s_d.sysrst = 1'b1;
        end
        // One shared interrupt line for all sources.
        s_d.irq = (s_d.tx_done && s_d.tx_ie) ||
                  (s_d.rx_done && s_d.rx_ie) ||
                  (s_d.sh_done && s_d.sh_ie) ||
                  (s_d.eop && s_d.eop_ie) ||
                  s_d.wakeup;
    end

    // Only the power-on reset clears the state, bus reset flag included.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign regs.rdata = s_q.rdata;
    assign regs.irq = s_q.irq;
    assign resp = s_q.resp;
    assign resp_valid = s_q.resp_valid;
    assign resp_data1 = s_q.data1;
    assign resp_count = s_q.resp_count;
    assign usb_pins_enable = s_q.enable;
    assign usb_clock_stop = s_q.suspend;
    assign analog_power_down = s_q.suspend;
    assign system_reset = s_q.sysrst;

endmodule : ulsep_dev

// *** ulsep_asserts.sv ***
// Concurrent checks on the register port joining the two ends.
// Assumes all signals belong to pclk and presetn is active low.
module ulsep_asserts (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Register port.
    input wire logic sel,
    input wire logic wr,
    input wire logic [1:0] idx,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic rd;
    logic [7:0] addr_q;
    logic [7:0] ie0_q;
    logic [7:0] ie1_q;
    logic [7:0] ctl_q;

    assign rd = sel && !wr;

    // Shadows of the last value written to each register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_q <= 8'h00;
            ie0_q <= 8'h00;
            ie1_q <= 8'h00;
            ctl_q <= 8'h00;
        end else if (sel && wr) begin
            case (idx)
                2'h0: addr_q <= wdata;
                2'h1: ie0_q <= wdata;
                2'h2: ie1_q <= wdata;
                default: ctl_q <= wdata;
            endcase
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_addr_readback: assert property (
        rd && idx == 2'h0 |=> rdata == addr_q)
        else $error("address register readback differs");
    a_ctl_readback: assert property (
        rd && idx == 2'h3 |=> {rdata[7], rdata[5:0]} == {ctl_q[7], ctl_q[5:0]})
        else $error("control register readback differs");
    a_strobe0_zero: assert property (
        rd && idx == 2'h1 |=> rdata[1:0] == 2'h0)
        else $error("clear strobes of irq0 do not read zero");
    a_strobe1_zero: assert property (
        rd && idx == 2'h2 |=> rdata[4] == 1'b0 && rdata[1:0] == 2'h0)
        else $error("clear strobes of irq1 do not read zero");
    a_irq0_enables: assert property (
        rd && idx == 2'h1 |=> rdata[4:2] == ie0_q[4:2])
        else $error("irq0 enables or suspend readback differs");
    a_irq1_enables: assert property (
        rd && idx == 2'h2 |=> rdata[3:2] == ie1_q[3:2])
        else $error("irq1 enables readback differs");
    a_irq0_raise: assert property (
        rd && idx == 2'h1 |=>
        !((rdata[7] && rdata[3]) || (rdata[6] && rdata[2])) || irq)
        else $error("enabled control flag without interrupt");
    a_irq1_raise: assert property (
        rd && idx == 2'h2 |=>
        !((rdata[7] && rdata[3]) || (rdata[6] && rdata[2]) || rdata[5]) || irq)
        else $error("enabled shared flag without interrupt");

    c_clear_tx: cover property (sel && wr && idx == 2'h1 && wdata[1]);
    c_irq_rise: cover property ($rose(irq));
    c_stall_seen: cover property (rd && idx == 2'h3 ##1 rdata[6]);
endmodule : ulsep_asserts

// *** usb_lowspeed_endpoint_ctrl_bench.sv ***
// Self-checking bench: APB commands to the controller, tokens and events to
// the device, expectations from a bench image of the register state.
// Assumes the package, interface and both design ends are compiled first.
module usb_lowspeed_endpoint_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic tok_valid, sh_ready, activity, resp_valid, resp_data1;
    logic pins_en, clk_stop, pwr_down, sys_rst;
    logic [4:0] evt;
    logic [6:0] tok_addr;
    logic [1:0] tok_ep;
    logic [3:0] resp_count;
    ulsep_pkg::ulsep_token_type tok_kind;
    ulsep_pkg::ulsep_resp_type resp;
    logic [7:0] r [4];
    int errors, n_tests;

    ulsep_if link();
    ulsep_ctrl #(.IDLE_COUNT(20)) u_ulsep_ctrl (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bus_activity(activity), .dev(link));
    ulsep_dev u_ulsep_dev (.pclk(pclk), .presetn(presetn), .regs(link),
        .token_valid(tok_valid), .token_kind(tok_kind), .token_addr(tok_addr),
        .token_ep(tok_ep), .shared_tx_ready(sh_ready), .ctl_tx_acked(evt[0]),
        .ctl_rx_acked(evt[1]), .shared_tx_acked(evt[2]), .eop_detect(evt[3]),
        .bus_reset_detect(evt[4]), .bus_activity(activity), .resp(resp),
        .resp_valid(resp_valid), .resp_data1(resp_data1),
        .resp_count(resp_count), .usb_pins_enable(pins_en),
        .usb_clock_stop(clk_stop), .analog_power_down(pwr_down),
        .system_reset(sys_rst));
    ulsep_asserts u_ulsep_asserts (.pclk(pclk), .presetn(presetn),
        .sel(link.sel), .wr(link.wr), .idx(link.idx), .wdata(link.wdata),
        .rdata(link.rdata), .irq(link.irq));

    task automatic give_verdict;
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    function automatic logic exp_irq();
        return (r[1][7] & r[1][3]) | (r[1][6] & r[1][2]) | (r[2][7] & r[2][3])
            | (r[2][6] & r[2][2]) | r[2][5];
    endfunction : exp_irq

    // One APB transfer; entered and left just after a rising edge.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            errors++;
            give_verdict();
        end
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Device register access through the controller, then a busy poll.
    task automatic dev_cmd(input logic [1:0] i, input logic [7:0] w,
                           input logic rd, output logic [7:0] v);
        logic [31:0] st;
        int k;
        apb(1'b1, ulsep_pkg::APB_INDEX, {30'h0, i}, st);
        apb(1'b1, ulsep_pkg::APB_WDATA, {24'h0, w}, st);
        apb(1'b1, ulsep_pkg::APB_CMD, {30'h0, rd, !rd}, st);
        k = 0;
        do begin
            apb(1'b0, ulsep_pkg::APB_STATUS, 32'h0, st);
            k++;
        end while (st[ulsep_pkg::ST_BUSY_BIT] !== 1'b0 && k < 20);
        if (st[ulsep_pkg::ST_BUSY_BIT] !== 1'b0) begin
            errors++;
            give_verdict();
        end
        v = st[ulsep_pkg::ST_RDATA_LSB +: 8];
    endtask : dev_cmd

    task automatic wr_reg(input logic [1:0] i, input logic [7:0] w);
        logic [7:0] v;
        dev_cmd(i, w, 1'b0, v);
        case (i)
            2'h1: r[1] = {r[1][7] & ~w[1], r[1][6] & ~w[0], r[1][5], w[4:2], 2'h0};
            2'h2: r[2] = {r[2][7] & ~w[1], r[2][6] & ~w[0], r[2][5] & ~w[4], 1'b0, w[3:2], 2'h0};
            default: r[i] = w;
        endcase
    endtask : wr_reg

    task automatic rd_reg(input logic [1:0] i);
        logic [7:0] v;
        dev_cmd(i, 8'h00, 1'b1, v);
        check(v, r[i]);
    endtask : rd_reg

    task automatic check_state;
        @(negedge pclk);
        check(link.irq, exp_irq());
        check(pins_en, r[0][7]);
        check({clk_stop, pwr_down}, {2{r[1][4]}});
        @(posedge pclk);
    endtask : check_state

    task automatic pulse(input int j);
        if (j < 5) evt[j] <= 1'b1;
        else activity <= 1'b1;
        @(posedge pclk);
        evt <= 5'h00;
        activity <= 1'b0;
        @(negedge pclk);
        check(sys_rst, j == 4);
        case (j)
            0: r[1][7] = 1'b1;
            1: r[1][6] = 1'b1;
            2: r[2][7] = 1'b1;
            3: r[2][6] = 1'b1;
            4: r[1][5] = 1'b1;
            default: r[2][5] = r[2][5] | r[1][4];
        endcase
        @(posedge pclk);
    endtask : pulse

    task automatic token;
        ulsep_pkg::ulsep_token_type k;
        ulsep_pkg::ulsep_resp_type e;
        logic [6:0] a;
        logic [1:0] ep;
        logic sr, v;
        k = ulsep_pkg::ulsep_token_type'($urandom_range(3));
        ep = 2'($urandom_range(2));
        a = ($urandom_range(7) == 0) ? 7'($urandom) : r[0][6:0];
        sr = 1'($urandom);
        tok_valid <= 1'b1;
        tok_kind <= k;
        tok_addr <= a;
        tok_ep <= ep;
        sh_ready <= sr;
        @(posedge pclk);
        tok_valid <= 1'b0;
        @(negedge pclk);
        v = r[0][7] && a == r[0][6:0] &&
            (ep == 2'h0 ? k != ulsep_pkg::TOK_OTHER : k == ulsep_pkg::TOK_IN);
        if (k == ulsep_pkg::TOK_SETUP) e = ulsep_pkg::RESP_ACK;
        else if (ep == 2'h0 && r[3][6]) e = ulsep_pkg::RESP_STALL;
        else if (k == ulsep_pkg::TOK_IN && ep == 2'h0) e = (!r[3][5] || r[1][7]) ? ulsep_pkg::RESP_NAK : ulsep_pkg::RESP_DATA;
        else if (k == ulsep_pkg::TOK_IN) e = (!sr || r[2][7]) ? ulsep_pkg::RESP_NAK : ulsep_pkg::RESP_DATA;
        else e = (!r[3][4] || r[1][6]) ? ulsep_pkg::RESP_NAK : ulsep_pkg::RESP_ACK;
        check(resp_valid, v);
        if (v) check(resp, e);
        if (v && ep == 2'h0 && e == ulsep_pkg::RESP_DATA) begin
            check(resp_data1, r[3][7]);
            check(resp_count, r[3][3:0]);
        end
        if (v && k == ulsep_pkg::TOK_SETUP) r[3][6] = 1'b0;
        @(posedge pclk);
    endtask : token

    task automatic do_reset;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        r = '{default: 8'h00};
        for (int i = 0; i < 4; i++) rd_reg(2'(i));
    endtask : do_reset

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        logic [31:0] st;
        int op;
        {presetn, psel, penable, pwrite, tok_valid, sh_ready, activity} = '0;
        {paddr, pwdata, tok_addr, tok_ep, evt} = '0;
        tok_kind = ulsep_pkg::TOK_OUT;
        errors = 0;
        n_tests = 0;
        void'($urandom(21538));
        do_reset();
        wr_reg(2'h0, {1'b1, 7'($urandom)});
        for (int n = 0; n < 400; n++) begin
            op = $urandom_range(10);
            if (op < 3) token();
            else if (op < 5) pulse($urandom_range(5));
            else if (op < 9) wr_reg(2'(op - 5), 8'($urandom) | (op == 5 ? 8'h80 : 8'h00));
            else rd_reg(2'($urandom_range(3)));
            check_state();
        end
        // Disabled module: tokens get no answer, pins are off.
        wr_reg(2'h0, {1'b0, r[0][6:0]});
        repeat (4) token();
        check_state();
        // Firmware frees the receive side, then re-enables it.
        wr_reg(2'h1, {3'h0, r[1][4:2], 2'h1});
        wr_reg(2'h3, r[3] | 8'h10);
        wr_reg(2'h0, r[0] | 8'h80);
        repeat (4) token();
        check_state();
        pulse(5);
        apb(1'b0, ulsep_pkg::APB_STATUS, 32'h0, st);
        check(st[ulsep_pkg::ST_IDLE_BIT], 1'b0);
        check(st[ulsep_pkg::ST_IRQ_BIT], exp_irq());
        repeat (30) @(posedge pclk);
        apb(1'b0, ulsep_pkg::APB_STATUS, 32'h0, st);
        check(st[ulsep_pkg::ST_IDLE_BIT], 1'b1);
        apb(1'b0, 8'h10, 32'h0, st);
        check(st, 32'h0);
        pulse(4);
        do_reset();
        give_verdict();
    end
endmodule : usb_lowspeed_endpoint_ctrl_bench
